/* File: imlx_consts.vh */
// Shared constants for the integer/float execution slice: opcode fields, minor codes,
// float format layout, rounding mode codes and float flag bits.
// Assumes the includer uses plain Verilog-2005 and includes this file by bare name.
`ifndef IMLX_CONSTS_VH
`define IMLX_CONSTS_VH

// ==================================================================
// Instruction field positions.
`define IMLX_MAJ_HI 31
`define IMLX_MAJ_LO 26
`define IMLX_F25_HI 25
`define IMLX_F25_LO 21
`define IMLX_F20_HI 20
`define IMLX_F20_LO 16
`define IMLX_F15_HI 15
`define IMLX_F15_LO 11
`define IMLX_IMM_HI 15
`define IMLX_IMM_LO 0
`define IMLX_BIT10 10
`define IMLX_MIN10_HI 9
`define IMLX_MIN10_LO 0
`define IMLX_FMUL_FMT_HI 9
`define IMLX_FMUL_FMT_LO 8
`define IMLX_FMUL_MIN_HI 7
`define IMLX_FMUL_MIN_LO 0
`define IMLX_FNEG_BIT15 15
`define IMLX_FNEG_FMT_HI 14
`define IMLX_FNEG_FMT_LO 13
`define IMLX_FNEG_MIN_HI 12
`define IMLX_FNEG_MIN_LO 6
`define IMLX_FNEG_EXT_HI 5
`define IMLX_FNEG_EXT_LO 0

// ==================================================================
// Opcode values.
`define IMLX_OP_GROUP_A 6'h00
`define IMLX_OP_FLOAT 6'h15
`define IMLX_OP_ORC 6'h14
`define IMLX_MIN_MUL_LS 10'h018
`define IMLX_MIN_MUL_HS 10'h058
`define IMLX_MIN_MUL_LU 10'h098
`define IMLX_MIN_MUL_HU 10'h0d8
`define IMLX_MIN_NOR 10'h2d0
`define IMLX_MIN_OR 10'h290
`define IMLX_MIN_FMUL 8'hb0
`define IMLX_MIN_FNEG 7'h2d
`define IMLX_EXT_FNEG 6'h3b
`define IMLX_FMT_S 2'h0
`define IMLX_FMT_D 2'h1

// ==================================================================
// Float format layout.
`define IMLX_S_SIGN 31
`define IMLX_D_SIGN 63
`define IMLX_S_EXP_ONES 8'hff
`define IMLX_D_EXP_ONES 11'h7ff
`define IMLX_S_BIAS 10'h07f
`define IMLX_D_BIAS 13'h03ff
`define IMLX_S_EMAX 10'h0fe
`define IMLX_D_EMAX 13'h07fe

// ==================================================================
// Rounding mode codes and float flag bits.
`define IMLX_RM_NEAR 2'h0
`define IMLX_RM_ZERO 2'h1
`define IMLX_RM_UP 2'h2
`define IMLX_RM_DOWN 2'h3
`define IMLX_FLG_INEXACT 0
`define IMLX_FLG_UNDER 1
`define IMLX_FLG_OVER 2
`define IMLX_FLG_INVALID 3
`define IMLX_FLG_UNIMPL 4
`define IMLX_FLG_W 5

`endif

/* File: imlx_int_mul.v */
// Integer multiplier: 32 by 32 bits, signed or unsigned, giving the 64-bit product.
// Assumes operands arrive already cut to 32 bits; purely combinational.
`timescale 1ns/1ns
`default_nettype none

// ==================================================================
// Multiplier.
module imlx_int_mul (
   input wire [31:0] op_a,
   input wire [31:0] op_b,
   input wire is_signed,
   output wire [63:0] product
);
   // Extending by one bit lets one signed multiplier cover both kinds.
   wire signed [32:0] ext_a = {is_signed & op_a[31], op_a};
   wire signed [32:0] ext_b = {is_signed & op_b[31], op_b};
   wire signed [65:0] full = ext_a * ext_b;
   // Only the low 64 bits carry meaning for 33x33 extended operands.
   assign product = full[63:0];
endmodule

`default_nettype wire

/* File: imlx_fp_mul.v */
// Float multiplier for single and double format, with the four rounding modes.
// Assumes operands are presented in the low bits for single format; combinational.
// Subnormal inputs are reported as unimplemented rather than computed, trading
// area for a smaller, simpler datapath; tiny results flush with underflow.
`timescale 1ns/1ns
`default_nettype none
`include "imlx_consts.vh"

// ==================================================================
// Float product core.
module imlx_fp_mul (
   input wire [63:0] op_a,
   input wire [63:0] op_b,
   input wire is_double,
   input wire [1:0] round_mode,
   output reg [63:0] result,
   output reg [4:0] flags
);
   reg sa, sb, sr;
   reg [12:0] ea, eb, er;
   reg [52:0] ma, mb;
   reg [105:0] prod;
   reg [53:0] keep;
   reg guard, sticky, rnd_up, a_nan, b_nan, a_inf, b_inf, a_zero, b_zero, a_sub, b_sub;
   reg [12:0] emax, bias;
   reg [10:0] eones;

   // Unpack, multiply, normalise, round and repack in one combinational pass.
   always @* begin
      result = 64'h0;
      flags = 5'h0;
      keep = 54'h0;
      guard = 1'b0;
      sticky = 1'b0;
      rnd_up = 1'b0;
      if (is_double) begin
         sa = op_a[`IMLX_D_SIGN];
         sb = op_b[`IMLX_D_SIGN];
         ea = {2'h0, op_a[62:52]};
         eb = {2'h0, op_b[62:52]};
         ma = {1'b1, op_a[51:0]};
         mb = {1'b1, op_b[51:0]};
         emax = `IMLX_D_EMAX;
         bias = `IMLX_D_BIAS;
         eones = `IMLX_D_EXP_ONES;
      end else begin
         sa = op_a[`IMLX_S_SIGN];
         sb = op_b[`IMLX_S_SIGN];
         ea = {5'h0, op_a[30:23]};
         eb = {5'h0, op_b[30:23]};
         ma = {1'b1, op_a[22:0], 29'h0};
         mb = {1'b1, op_b[22:0], 29'h0};
         emax = {3'h0, `IMLX_S_EMAX};
         bias = {3'h0, `IMLX_S_BIAS};
         eones = {3'h0, `IMLX_S_EXP_ONES};
      end
      sr = sa ^ sb;
      a_inf = (ea[10:0] == eones) && (ma[51:0] == 52'h0);
      b_inf = (eb[10:0] == eones) && (mb[51:0] == 52'h0);
      a_nan = (ea[10:0] == eones) && !a_inf;
      b_nan = (eb[10:0] == eones) && !b_inf;
      a_zero = (ea == 13'h0) && (ma[51:0] == 52'h0);
      b_zero = (eb == 13'h0) && (mb[51:0] == 52'h0);
      a_sub = (ea == 13'h0) && !a_zero;
      b_sub = (eb == 13'h0) && !b_zero;
      prod = ma * mb;
      // Normalise: the product lies in [1,4).
      if (prod[105]) begin
         keep = {1'b0, prod[105:53]};
         guard = prod[52];
         sticky = |prod[51:0];
         er = ea + eb - bias + 13'h1;
      end else begin
         keep = {1'b0, prod[104:52]};
         guard = prod[51];
         sticky = |prod[50:0];
         er = ea + eb - bias;
      end
      if (!is_double) begin
         // Single precision keeps 24 bits; fold lower bits into guard and sticky.
         sticky = sticky | guard | (|keep[27:0]);
         guard = keep[28];
         keep = keep >> 29;
      end
      // Rounding decision for the current mode.
      case (round_mode)
         `IMLX_RM_NEAR: rnd_up = guard & (sticky | keep[0]);
         `IMLX_RM_ZERO: rnd_up = 1'b0;
         `IMLX_RM_UP: rnd_up = !sr & (guard | sticky);
         `IMLX_RM_DOWN: rnd_up = sr & (guard | sticky);
         default: rnd_up = 1'b0;
      endcase
      keep = keep + {53'h0, rnd_up};
      if ((is_double && keep[53]) || (!is_double && keep[24])) begin
         keep = keep >> 1;
         er = er + 13'h1;
      end
      flags[`IMLX_FLG_INEXACT] = guard | sticky;
      // Special operands take priority over the computed value.
      if (a_sub || b_sub) begin
         flags = 5'h0;
         flags[`IMLX_FLG_UNIMPL] = 1'b1;
      end else if (a_nan || b_nan || ((a_inf || b_inf) && (a_zero || b_zero))) begin
         flags = 5'h0;
         flags[`IMLX_FLG_INVALID] = 1'b1;
         result = is_double ? 64'h7ff7ffffffffffff : 64'h000000007fbfffff;
      end else if (a_inf || b_inf) begin
         flags = 5'h0;
         result = is_double ? {sr, 11'h7ff, 52'h0} : {32'h0, sr, 8'hff, 23'h0};
      end else if (a_zero || b_zero) begin
         flags = 5'h0;
         result = is_double ? {sr, 63'h0} : {32'h0, sr, 31'h0};
      end else if (er[12] || er == 13'h0) begin
         flags[`IMLX_FLG_UNDER] = 1'b1;
         flags[`IMLX_FLG_INEXACT] = 1'b1;
         result = is_double ? {sr, 63'h0} : {32'h0, sr, 31'h0};
      end else if (er > emax) begin
         flags[`IMLX_FLG_OVER] = 1'b1;
         flags[`IMLX_FLG_INEXACT] = 1'b1;
         if (round_mode == `IMLX_RM_ZERO || (round_mode == `IMLX_RM_UP && sr)
             || (round_mode == `IMLX_RM_DOWN && !sr)) begin
            result = is_double ? {sr, 11'h7fe, {52{1'b1}}} : {32'h0, sr, 8'hfe, 23'h7fffff};
         end else begin
            result = is_double ? {sr, 11'h7ff, 52'h0} : {32'h0, sr, 8'hff, 23'h0};
         end
      end else if (is_double) begin
         result = {sr, er[10:0], keep[51:0]};
      end else begin
         result = {32'h0, sr, er[7:0], keep[22:0]};
      end
   end
endmodule

`default_nettype wire

/* File: imlx_exec.v */
// Execution slice for integer multiply, NOR, OR, OR-with-constant, the idle word,
// float multiply and float sign flip. One instruction per enabled cycle; results and
// float flags leave on registered write-back ports one cycle later.
// Assumes decode supplies the raw word and operands read from both register files.
//
// Overview of operation
// - Signed multiply, keep low product word.
// - Signed multiply, keep high product word.
// - Unsigned multiply, keep low product word.
// - Unsigned multiply, keep high product word.
// - Multiplies read only operand bits 31..0.
// - Four multiply minor codes under group opcode.
// - Float product rounded by current control mode.
// - Float multiply decode: opcode, minor, format.
// - Float multiply may raise five float flags.
// - Sign flip inverts sign, same format.
// - Arithmetic flip flags invalid on NaN.
// - Non-arithmetic flip never raises any flag.
// - Sign flip decode: opcode, minor, extended code.
// - All-zero word is idle, changes nothing.
// - NOR writes inverted OR, no exception.
// - NOR decode under group opcode, bit ten zero.
// - OR writes bitwise OR, no exception.
// - OR decode under group opcode, bit ten zero.
// - Zero-extend constant, OR with source.
// - Constant OR decode and field positions.
`timescale 1ns/1ns
`default_nettype none
`include "imlx_consts.vh"

// ==================================================================
// Top module.
module imlx_exec (
   input wire clk,
   input wire rst_n,
   input wire clk_en,
   input wire issue_valid,
   input wire [31:0] instr_word,
   input wire [63:0] int_src_a,
   input wire [63:0] int_src_b,
   input wire [63:0] float_src_a,
   input wire [63:0] float_src_b,
   input wire [1:0] float_round_mode,
   input wire sign_op_nonarith_enable,
   input wire ieee2008_capable,
   output reg int_wr_en,
   output reg [4:0] int_wr_addr,
   output reg [63:0] int_wr_data,
   output reg float_wr_en,
   output reg [4:0] float_wr_addr,
   output reg [63:0] float_wr_data,
   output reg [4:0] float_flags,
   output reg float_flags_valid,
   output reg illegal_instr
);
   // Field extraction.
   wire [5:0] major = instr_word[`IMLX_MAJ_HI:`IMLX_MAJ_LO];
   wire [4:0] f25 = instr_word[`IMLX_F25_HI:`IMLX_F25_LO];
   wire [4:0] f15 = instr_word[`IMLX_F15_HI:`IMLX_F15_LO];
   wire [9:0] min10 = instr_word[`IMLX_MIN10_HI:`IMLX_MIN10_LO];
   wire [15:0] imm = instr_word[`IMLX_IMM_HI:`IMLX_IMM_LO];
   wire b10_zero = !instr_word[`IMLX_BIT10];
   wire grp_a = (major == `IMLX_OP_GROUP_A);
   wire grp_f = (major == `IMLX_OP_FLOAT);

   // Decode strobes.
   wire dec_mul_ls = grp_a && b10_zero && (min10 == `IMLX_MIN_MUL_LS);
   wire dec_mul_hs = grp_a && b10_zero && (min10 == `IMLX_MIN_MUL_HS);
   wire dec_mul_lu = grp_a && b10_zero && (min10 == `IMLX_MIN_MUL_LU);
   wire dec_mul_hu = grp_a && b10_zero && (min10 == `IMLX_MIN_MUL_HU);
   wire dec_nor = grp_a && b10_zero && (min10 == `IMLX_MIN_NOR);
   wire dec_or = grp_a && b10_zero && (min10 == `IMLX_MIN_OR);
   wire dec_orc = (major == `IMLX_OP_ORC);
   wire dec_idle = (instr_word == 32'h0);
   wire [1:0] fmul_fmt = instr_word[`IMLX_FMUL_FMT_HI:`IMLX_FMUL_FMT_LO];
   wire [1:0] fneg_fmt = instr_word[`IMLX_FNEG_FMT_HI:`IMLX_FNEG_FMT_LO];
   wire dec_fmul = grp_f && b10_zero &&
                   (instr_word[`IMLX_FMUL_MIN_HI:`IMLX_FMUL_MIN_LO] == `IMLX_MIN_FMUL);
   wire dec_fneg = grp_f && !instr_word[`IMLX_FNEG_BIT15] &&
                   (instr_word[`IMLX_FNEG_MIN_HI:`IMLX_FNEG_MIN_LO] == `IMLX_MIN_FNEG) &&
                   (instr_word[`IMLX_FNEG_EXT_HI:`IMLX_FNEG_EXT_LO] == `IMLX_EXT_FNEG);
   // Only single and double formats exist; other selectors are refused.
   wire fmul_fmt_ok = (fmul_fmt == `IMLX_FMT_S) || (fmul_fmt == `IMLX_FMT_D);
   wire fneg_fmt_ok = (fneg_fmt == `IMLX_FMT_S) || (fneg_fmt == `IMLX_FMT_D);
   wire dec_mul = dec_mul_ls | dec_mul_hs | dec_mul_lu | dec_mul_hu;
   wire dec_logic = dec_nor | dec_or;

   // ==================================================================
   // Integer multiplier.
   wire [63:0] int_prod;
   imlx_int_mul u_int_mul (
      .op_a(int_src_a[31:0]),
      .op_b(int_src_b[31:0]),
      .is_signed(dec_mul_ls | dec_mul_hs),
      .product(int_prod)
   );

   // ==================================================================
   // Float multiplier.
   wire [63:0] fmul_res;
   wire [4:0] fmul_flags;
   imlx_fp_mul u_fp_mul (
      .op_a(float_src_a),
      .op_b(float_src_b),
      .is_double(fmul_fmt == `IMLX_FMT_D),
      .round_mode(float_round_mode),
      .result(fmul_res),
      .flags(fmul_flags)
   );

   // Sign flip and its NaN test for the chosen format.
   wire fneg_dbl = (fneg_fmt == `IMLX_FMT_D);
   wire s_nan = (float_src_a[30:23] == `IMLX_S_EXP_ONES) && (|float_src_a[22:0]);
   wire d_nan = (float_src_a[62:52] == `IMLX_D_EXP_ONES) && (|float_src_a[51:0]);
   wire fneg_nan = fneg_dbl ? d_nan : s_nan;
   wire fneg_arith = !ieee2008_capable || !sign_op_nonarith_enable;
   wire [63:0] fneg_res = fneg_dbl ?
      {~float_src_a[`IMLX_D_SIGN], float_src_a[62:0]} :
      {32'h0, ~float_src_a[`IMLX_S_SIGN], float_src_a[30:0]};

   // Result mux for the integer path; results are 32-bit words, sign-extended.
   reg [31:0] int_word;
   reg [4:0] int_dest;
   always @* begin
      int_word = 32'h0;
      int_dest = f15;
      if (dec_mul_ls || dec_mul_lu) begin
         int_word = int_prod[31:0];
      end else if (dec_mul_hs || dec_mul_hu) begin
         int_word = int_prod[63:32];
      end else if (dec_nor) begin
         int_word = ~(int_src_a[31:0] | int_src_b[31:0]);
      end else if (dec_or) begin
         int_word = int_src_a[31:0] | int_src_b[31:0];
      end else if (dec_orc) begin
         int_word = int_src_a[31:0] | {16'h0, imm};
         int_dest = f25;
      end
   end

   // ==================================================================
   // Write-back registers. Every enabled cycle clears enables so nothing else is touched; a stall holds them.
   always @(posedge clk) begin
      if (!rst_n) begin
         int_wr_en <= 1'b0;
         int_wr_addr <= 5'h0;
         int_wr_data <= 64'h0;
         float_wr_en <= 1'b0;
         float_wr_addr <= 5'h0;
         float_wr_data <= 64'h0;
         float_flags <= 5'h0;
         float_flags_valid <= 1'b0;
         illegal_instr <= 1'b0;
      end else if (clk_en) begin
         int_wr_en <= 1'b0;
         float_wr_en <= 1'b0;
         float_flags_valid <= 1'b0;
         illegal_instr <= 1'b0;
         if (issue_valid && !dec_idle) begin
            if (dec_mul || dec_logic || dec_orc) begin
               // Register zero is hard-wired; its writes are dropped here.
               int_wr_en <= (int_dest != 5'h0);
               int_wr_addr <= int_dest;
               int_wr_data <= {{32{int_word[31]}}, int_word};
            end else if (dec_fmul && fmul_fmt_ok) begin
               float_wr_en <= 1'b1;
               float_wr_addr <= f15;
               float_wr_data <= fmul_res;
               float_flags <= fmul_flags;
               float_flags_valid <= 1'b1;
            end else if (dec_fneg && fneg_fmt_ok) begin
               float_wr_en <= 1'b1;
               float_wr_addr <= f25;
               float_wr_data <= fneg_res;
               float_flags <= 5'h0;
               if (fneg_arith && fneg_nan) begin
                  float_flags <= 5'h1 << `IMLX_FLG_INVALID;
               end
               float_flags_valid <= fneg_arith;
            end else if (dec_fmul || dec_fneg) begin
               // A bad format selector is a reserved instruction.
               illegal_instr <= 1'b1;
            end
         end
      end
   end
endmodule

`default_nettype wire

/* File: imlx_exec_props.sv */
// Checker for the write-back ports of the execution slice.
// Assumes it is bound to imlx_exec and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none

// ==================================================================
// Checker module.
module imlx_exec_props (
   input wire clk,
   input wire rst_n,
   input wire clk_en,
   input wire issue_valid,
   input wire [31:0] instr_word,
   input wire [63:0] int_src_a,
   input wire [63:0] int_src_b,
   input wire [63:0] float_src_a,
   input wire [63:0] float_src_b,
   input wire [1:0] float_round_mode,
   input wire sign_op_nonarith_enable,
   input wire ieee2008_capable,
   input wire int_wr_en,
   input wire [4:0] int_wr_addr,
   input wire [63:0] int_wr_data,
   input wire float_wr_en,
   input wire [4:0] float_wr_addr,
   input wire [63:0] float_wr_data,
   input wire [4:0] float_flags,
   input wire float_flags_valid,
   input wire illegal_instr
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // ==================================================================
   // Copy of the taken request, so results can be tied to their cause.
   reg tk_q;
   reg na_q;
   reg [31:0] w_q;
   reg [63:0] a_q, b_q, f_q;

   // Capture only on enabled edges, since the slice freezes with clk_en low.
   always @(posedge clk) begin
      if (!rst_n) begin
         tk_q <= 1'b0;
      end else if (clk_en) begin
         tk_q <= issue_valid;
         na_q <= sign_op_nonarith_enable & ieee2008_capable;
         w_q <= instr_word;
         a_q <= int_src_a;
         b_q <= int_src_b;
         f_q <= float_src_a;
      end
   end

   // Decode of the captured word.
   wire grp = (w_q[31:26] == 6'h00) && !w_q[10];
   wire [4:0] rd = w_q[15:11];
   wire q_or = grp && (w_q[9:0] == 10'h290);
   wire q_nor = grp && (w_q[9:0] == 10'h2d0);
   wire q_mhu = grp && (w_q[9:0] == 10'h0d8);
   wire q_mls = grp && (w_q[9:0] == 10'h018);
   wire q_orc = (w_q[31:26] == 6'h14);
   wire q_neg = (w_q[31:26] == 6'h15) && !w_q[15] && !w_q[14] && (w_q[12:0] == 13'h0b7b);
   wire [31:0] or32 = a_q[31:0] | b_q[31:0];
   wire [31:0] nor32 = ~or32;
   wire [63:0] pu = {32'h0, a_q[31:0]} * {32'h0, b_q[31:0]};
   wire signed [63:0] ps = $signed(a_q[31:0]) * $signed(b_q[31:0]);

   // ==================================================================
   // Assertions.
   AST_ZERO_DEST: assert property (int_wr_en |-> int_wr_addr != 5'h00)
      else $error("integer write aimed at register zero");
   AST_OR_DATA: assert property (tk_q && q_or && rd != 5'h00 |->
      int_wr_en && int_wr_addr == rd && int_wr_data == {{32{or32[31]}}, or32})
      else $error("bitwise or result wrong");
   AST_NOR_DATA: assert property (tk_q && q_nor && rd != 5'h00 |->
      int_wr_en && int_wr_data == {{32{nor32[31]}}, nor32})
      else $error("bitwise nor result wrong");
   AST_ORC_DATA: assert property (tk_q && q_orc && w_q[25:21] != 5'h00 |-> int_wr_en &&
      int_wr_addr == w_q[25:21] && int_wr_data[31:0] == (a_q[31:0] | {16'h0, w_q[15:0]}))
      else $error("or with constant result wrong");
   AST_MUL_HU: assert property (tk_q && q_mhu && rd != 5'h00 |->
      int_wr_data[31:0] == pu[63:32])
      else $error("unsigned high product wrong");
   AST_MUL_LS: assert property (tk_q && q_mls && rd != 5'h00 |->
      int_wr_data == {{32{ps[31]}}, ps[31:0]})
      else $error("signed low product wrong");
   AST_IDLE: assert property ((clk_en && issue_valid && instr_word == 32'h0) |=>
      !int_wr_en && !float_wr_en && !float_flags_valid)
      else $error("idle word changed state");
   AST_NEG_QUIET: assert property (tk_q && q_neg && na_q |->
      float_wr_en && !float_flags_valid)
      else $error("non-arithmetic sign flip reported flags");
   AST_NEG_DATA: assert property (tk_q && q_neg && w_q[13] |->
      float_wr_data == {~f_q[63], f_q[62:0]} && float_wr_addr == w_q[25:21])
      else $error("double sign flip result wrong");

   // Main scenarios reached.
   cover property (tk_q && q_mhu);
   cover property (float_flags_valid && float_flags[3]);
   cover property (illegal_instr);
endmodule

`default_nettype wire

/* File: imlx_wb_model.sv */
// Write-back side of the pipeline: counts the register writes it accepts.
// Assumes writes are taken on enabled rising edges only, as a stalled core does.
`timescale 1ns/1ns
`default_nettype none

// ==================================================================
// Write-back sink.
module imlx_wb_model (
   input wire clk,
   input wire rst_n,
   input wire clk_en,
   input wire int_wr_en,
   input wire float_wr_en,
   output logic [15:0] wr_count
);
   // A frozen pulse must count once, so the stall gates the count.
   always @(posedge clk) begin
      if (!rst_n) begin
         wr_count <= 16'h0000;
      end else if (clk_en && (int_wr_en || float_wr_en)) begin
         wr_count <= wr_count + 16'h0001;
      end
   end
endmodule

`default_nettype wire

/* File: int_mul_logic_fp_mul_neg_exec_tb.sv */
// Self-checking bench for the execution slice, random and corner cases.
// Assumes a 10 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ns
`default_nettype none

// ==================================================================
// Bench top.
module int_mul_logic_fp_mul_neg_exec_tb;
   logic clk, rst_n, clk_en, issue_valid, sign_op_nonarith_enable, ieee2008_capable;
   logic [31:0] instr_word, rnd;
   logic [63:0] int_src_a, int_src_b, float_src_a, float_src_b;
   logic [1:0] float_round_mode;
   logic int_wr_en, float_wr_en, float_flags_valid, illegal_instr;
   logic [4:0] int_wr_addr, float_wr_addr, float_flags, rd;
   logic [63:0] int_wr_data, float_wr_data;
   logic [15:0] wr_count;
   int num_errors, cmp_count, exp_wr, i, k;

   imlx_exec i_imlx_exec (.clk, .rst_n, .clk_en, .issue_valid, .instr_word, .int_src_a,
      .int_src_b, .float_src_a, .float_src_b, .float_round_mode, .sign_op_nonarith_enable,
      .ieee2008_capable, .int_wr_en, .int_wr_addr, .int_wr_data, .float_wr_en, .float_wr_addr,
      .float_wr_data, .float_flags, .float_flags_valid, .illegal_instr);
   imlx_wb_model i_imlx_wb_model (.clk, .rst_n, .clk_en, .int_wr_en, .float_wr_en, .wr_count);

   // Clock of 100 ns period.
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ==================================================================
   // Helpers.
   function [31:0] nxt();
      rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
      nxt = rnd;
   endfunction
   function [63:0] sx(input [31:0] v);
      sx = {{32{v[31]}}, v};
   endfunction
   function [9:0] mn(input int m);
      mn = (m == 0) ? 10'h018 : (m == 1) ? 10'h058 : (m == 2) ? 10'h098 :
         (m == 3) ? 10'h0d8 : (m == 4) ? 10'h2d0 : 10'h290;
   endfunction
   // Expected integer result; kinds 0..3 multiply, 4 nor, 5 or, 6 or with constant.
   function [63:0] exp_int(input int m, input [63:0] a, input [63:0] b);
      logic [63:0] pu;
      logic signed [63:0] ps;
      pu = {32'h0, a[31:0]} * {32'h0, b[31:0]};
      ps = $signed(a[31:0]) * $signed(b[31:0]);
      case (m)
         0: exp_int = sx(ps[31:0]);
         1: exp_int = sx(ps[63:32]);
         2: exp_int = sx(pu[31:0]);
         3: exp_int = sx(pu[63:32]);
         4: exp_int = sx(~(a[31:0] | b[31:0]));
         5: exp_int = sx(a[31:0] | b[31:0]);
         default: exp_int = sx(a[31:0] | {16'h0, b[15:0]});
      endcase
   endfunction

   task chk(input string name, input [63:0] seen, input [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Issue one word at a falling edge and look at the result one cycle on.
   task op(input [31:0] w, input ei, input ef, input [4:0] r, input [63:0] d);
      instr_word = w;
      issue_valid = 1'b1;
      @(negedge clk);
      chk("int_wr_en", int_wr_en, ei && clk_en);
      chk("float_wr_en", float_wr_en, ef && clk_en);
      if (ei && clk_en) begin
         chk("int_wr_addr", int_wr_addr, r);
         chk("int_wr_data", int_wr_data, d);
      end
      if (ef && clk_en) begin
         chk("float_wr_addr", float_wr_addr, r);
         chk("float_wr_data", float_wr_data, d);
      end
      exp_wr += ((ei || ef) && clk_en);
   endtask
   task fchk(input fv, input [4:0] fl, input il);
      chk("float_flags_valid", float_flags_valid, fv);
      if (fv) begin
         chk("float_flags", float_flags, fl);
      end
      chk("illegal_instr", illegal_instr, il);
   endtask
   task fm(input [1:0] f, input [63:0] a, input [63:0] b, input [1:0] m, input [63:0] e,
      input [4:0] fl);
      float_src_a = a;
      float_src_b = b;
      float_round_mode = m;
      op({6'h15, 5'h02, 5'h01, 5'h06, 1'b0, f, 8'hb0}, 1'b0, 1'b1, 5'h06, e);
      fchk(1'b1, fl, 1'b0);
   endtask
   task fn(input [1:0] f, input [63:0] a, input na, input h, input [63:0] e, input fv,
      input [4:0] fl);
      float_src_a = a;
      sign_op_nonarith_enable = na;
      ieee2008_capable = h;
      op({6'h15, 5'h09, 5'h01, 1'b0, f, 7'h2d, 6'h3b}, 1'b0, 1'b1, 5'h09, e);
      fchk(fv, fl, 1'b0);
   endtask

   task tally_and_finish;
      if (num_errors == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Watchdog: the run needs about a hundred cycles.
   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      tally_and_finish;
   end

   // ==================================================================
   // Main sequence.
   initial begin
      rst_n = 1'b0; clk_en = 1'b1; issue_valid = 1'b0; instr_word = 32'h0;
      int_src_a = 64'h0; int_src_b = 64'h0; float_src_a = 64'h0; float_src_b = 64'h0;
      float_round_mode = 2'h0; sign_op_nonarith_enable = 1'b0; ieee2008_capable = 1'b1;
      rnd = 32'h0000002c; num_errors = 0; cmp_count = 0; exp_wr = 0;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      // Multiply corner operands with garbage in the upper halves.
      for (k = 0; k < 4; k++) begin
         int_src_a = 64'h12345678ffffffff;
         int_src_b = 64'hdeadbeef80000000;
         op({6'h00, 5'h03, 5'h04, 5'h1f, 1'b0, mn(k)}, 1'b1, 1'b0, 5'h1f,
            exp_int(k, int_src_a, int_src_b));
      end
      // Random traffic over all integer kinds, register zero included.
      for (i = 0; i < 60; i++) begin
         k = nxt() % 7;
         rd = 5'(nxt());
         int_src_a = {nxt(), nxt()};
         int_src_b = {nxt(), nxt()};
         if (k > 3) begin
            int_src_a = sx(int_src_a[31:0]);
            int_src_b = sx(int_src_b[31:0]);
         end
         instr_word = (k == 6) ? {6'h14, rd, 5'h04, int_src_b[15:0]} :
            {6'h00, 5'h03, 5'h04, rd, 1'b0, mn(k)};
         op(instr_word, rd != 5'h00, 1'b0, rd, exp_int(k, int_src_a,
            int_src_b));
      end
      // Idle, unknown and bit-ten-set words; then a stalled issue.
      op(32'h0, 1'b0, 1'b0, 5'h00, 64'h0);
      op(32'hffffffff, 1'b0, 1'b0, 5'h00, 64'h0);
      op({6'h00, 5'h03, 5'h04, 5'h05, 1'b1, 10'h290}, 1'b0, 1'b0, 5'h00, 64'h0);
      clk_en = 1'b0;
      op({6'h00, 5'h03, 5'h04, 5'h05, 1'b0, 10'h290}, 1'b1, 1'b0, 5'h05, 64'h0);
      clk_en = 1'b1;
      // Float products, the rounding modes and the exception flags.
      fm(2'h0, 64'h40000000, 64'h40400000, 2'h0, 64'h40c00000, 5'h00);
      fm(2'h1, 64'h4000000000000000, 64'h4008000000000000, 2'h0,
         64'h4018000000000000, 5'h00);
      fm(2'h0, 64'h3f800001, 64'h3f800001, 2'h0, 64'h3f800002, 5'h01);
      fm(2'h0, 64'h3f800001, 64'h3f800001, 2'h1, 64'h3f800002, 5'h01);
      fm(2'h0, 64'h3f800001, 64'h3f800001, 2'h2, 64'h3f800003, 5'h01);
      fm(2'h0, 64'h3f800001, 64'h3f800001, 2'h3, 64'h3f800002, 5'h01);
      fm(2'h0, 64'h7f000000, 64'h7f000000, 2'h0, 64'h7f800000, 5'h05);
      fm(2'h0, 64'h7f800000, 64'h0, 2'h0, 64'h7fbfffff, 5'h08);
      fm(2'h0, 64'h00800000, 64'h00800000, 2'h0, 64'h0, 5'h03);
      op({6'h15, 5'h02, 5'h01, 5'h06, 1'b0, 2'h2, 8'hb0}, 1'b0, 1'b0, 5'h00, 64'h0);
      fchk(1'b0, 5'h00, 1'b1);
      // Sign flips in both modes, on numbers and on quiet NaNs.
      fn(2'h1, 64'h3ff0000000000000, 1'b0, 1'b1, 64'hbff0000000000000, 1'b1, 5'h00);
      fn(2'h0, 64'h7fc00000, 1'b0, 1'b1, 64'hffc00000, 1'b1, 5'h08);
      fn(2'h0, 64'h7fc00000, 1'b1, 1'b1, 64'hffc00000, 1'b0, 5'h00);
      fn(2'h1, 64'h7ff8000000000000, 1'b0, 1'b0, 64'hfff8000000000000, 1'b1, 5'h08);
      issue_valid = 1'b0;
      repeat (2) @(negedge clk);
      chk("wr_count", wr_count, exp_wr);
      tally_and_finish;
   end
endmodule

bind imlx_exec imlx_exec_props i_props (.clk, .rst_n, .clk_en, .issue_valid, .instr_word,
   .int_src_a, .int_src_b, .float_src_a, .float_src_b, .float_round_mode,
   .sign_op_nonarith_enable, .ieee2008_capable, .int_wr_en, .int_wr_addr, .int_wr_data,
   .float_wr_en, .float_wr_addr, .float_wr_data, .float_flags, .float_flags_valid,
   .illegal_instr);

`default_nettype wire
